/* pkg/spl_map.svh */
// constants for the secure page lock status block
// assumes a 20 MHz system clock and a master-made serial clock
`ifndef SPL_MAP_SVH
`define SPL_MAP_SVH

// slave address headers
`define SPL_HDR_SEC      4'hb
`define SPL_HDR_ARR      4'ha

// first address byte bits [2:1]
`define SPL_KIND_SEC     2'h0
`define SPL_KIND_UID     2'h1
`define SPL_KIND_LOCK    2'h2
`define SPL_KIND_CFG     2'h3

// fixed bytes
`define SPL_ERASED       8'hff
`define SPL_ZERO         8'h00
`define SPL_ADDR_LOCK    8'h04
`define SPL_LOCK_POS     1

// configuration layout: select bits [7:5], swp bit 1, rest reads as ones
`define SPL_CFG_SEL_HI   7
`define SPL_CFG_SEL_LO   5
`define SPL_CFG_SWP_POS  1
`define SPL_CFG_DC_ONES  8'h1d
`define SPL_SEL_RST      3'h0
`define SPL_SWP_RST      1'b0
`define SPL_LOCK_RST     1'b0

// bit counting
`define SPL_BITS_BYTE    4'h8
`define SPL_DATA_BYTE    2'h3

// serial clock timing
`define SPL_CLK_PERIOD_NS 50
`define SPL_SCL_PERIOD_NS 10000
`define SPL_QTR_CYC      (`SPL_SCL_PERIOD_NS / `SPL_CLK_PERIOD_NS / 4)

// host step numbers where a refused byte resumes
`define SPL_PROBE_TAIL   4'h5
`define SPL_STAT_TAIL    4'h7

`endif

/* pkg/spl_pkg.sv */
// types for the secure page lock status block
// assumes spl_map.svh holds every number
package spl_pkg;

    typedef enum logic [4:0] {
        DS_IDLE = 5'h01,
        DS_RX   = 5'h02,
        DS_ACK  = 5'h04,
        DS_TX   = 5'h08,
        DS_MACK = 5'h10
    } spl_dev_st_t;

    typedef enum logic [4:0] {
        HS_IDLE  = 5'h01,
        HS_START = 5'h02,
        HS_STOP  = 5'h04,
        HS_WRB   = 5'h08,
        HS_RDB   = 5'h10
    } spl_host_st_t;

    typedef enum logic [1:0] {
        OP_PROBE  = 2'h1,
        OP_STATUS = 2'h2
    } spl_op_t;

    typedef struct packed {
        spl_host_st_t st;
        logic [7:0]   data;
    } spl_act_t;

    typedef struct packed {
        spl_dev_st_t st;
        logic [2:0]  scl_sy;
        logic [2:0]  sda_sy;
        logic [3:0]  bitc;
        logic [7:0]  sh;
        logic [1:0]  nbyte;
        logic        arr;
        logic        rw;
        logic [1:0]  kind;
        logic        lock;
        logic [2:0]  sel;
        logic        swp;
        logic        sda_oe;
    } spl_dev_s_t;

    typedef struct packed {
        spl_host_st_t st;
        logic [1:0]   q;
        logic [5:0]   div;
        logic [3:0]   step;
        logic [3:0]   bitc;
        logic [7:0]   sh;
        spl_op_t      op;
        logic [2:0]   sel;
        logic [1:0]   sda_sy;
        logic         nack;
        logic         scl;
        logic         sda_oe;
        logic         busy;
        logic         done;
        logic         acked;
        logic [7:0]   status;
        logic         locked;
    } spl_host_s_t;

endpackage : spl_pkg

/* pkg/spl_if.sv */
// two-wire link between the lock status master and the eeprom end
// open-drain data line resolved here with a pull-up; scl from master only
`timescale 1ns/100ps
interface spl_if;
    logic scl;
    logic sda;
    logic sda_h_o;
    logic sda_h_oe;
    logic sda_d_o;
    logic sda_d_oe;

    // wired-and with pull-up
    assign sda = ~((sda_h_oe & ~sda_h_o) | (sda_d_oe & ~sda_d_o));

    modport dev  (input scl, input sda, output sda_d_o, output sda_d_oe);
    modport host (output scl, output sda_h_o, output sda_h_oe, input sda);
endinterface : spl_if

/* core/spl_dev.sv */
// eeprom end: slave decode, secure page lock and lock status read
// assumes scl and sda arrive asynchronously through spl_if
//
// Notes on behaviour
// - secure page write acked only when unlocked
// - master ends probe with start then stop
// - lock status header is 1011 plus select
// - dummy write address has bits 2:1 = 10
// - read uses same 1011 header as dummy
// - status byte bit 1 shows lock state
// - shipped array reads erased ffh
// - shipped configuration reads 1dh
// - locked page refuses writes, stays readable
// - select bits must match configuration
// - configuration don't care bits read ones
`timescale 1ns/100ps
`include "spl_map.svh"
module spl_dev (
    // system
    input  wire logic clk,
    input  wire logic arst_n,
    // link
    spl_if.dev        bus,
    // user side
    output wire logic locked,
    output wire logic dev_select_bit2,
    output wire logic dev_select_bit1,
    output wire logic dev_select_bit0,
    output wire logic write_protect
);

    // byte the device shifts out for the current selection
    function automatic logic [7:0] tx_byte(
        input logic       arr,
        input logic [1:0] kind,
        input logic       lock,
        input logic [2:0] sel,
        input logic       swp
    );
        logic [7:0] b;
        b = `SPL_ERASED;
        if (!arr && kind == `SPL_KIND_LOCK) begin
            b = `SPL_ZERO;
            b[`SPL_LOCK_POS] = lock;
        end else if (!arr && kind == `SPL_KIND_CFG) begin
            b = `SPL_CFG_DC_ONES;
            b[`SPL_CFG_SEL_HI:`SPL_CFG_SEL_LO] = sel;
            b[`SPL_CFG_SWP_POS] = swp;
        end
        return b;
    endfunction : tx_byte

    spl_pkg::spl_dev_s_t s_reg;
    spl_pkg::spl_dev_s_t s_next;

    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;

    // edges use the second and third stages only
    assign scl_rise   = s_reg.scl_sy[1] & ~s_reg.scl_sy[2];
    assign scl_fall   = ~s_reg.scl_sy[1] & s_reg.scl_sy[2];
    assign start_cond = s_reg.scl_sy[1] & s_reg.scl_sy[2] &
                        ~s_reg.sda_sy[1] & s_reg.sda_sy[2];
    assign stop_cond  = s_reg.scl_sy[1] & s_reg.scl_sy[2] &
                        s_reg.sda_sy[1] & ~s_reg.sda_sy[2];

    always_comb begin
        logic       ack;
        logic       hit_sec;
        logic       hit_arr;
        logic [7:0] tx;
        ack     = 1'b0;
        hit_sec = 1'b0;
        hit_arr = 1'b0;
        tx      = `SPL_ERASED;
        s_next  = s_reg;
        s_next.scl_sy = {s_reg.scl_sy[1:0], bus.scl};
        s_next.sda_sy = {s_reg.sda_sy[1:0], bus.sda};
        if (start_cond) begin
            // kind survives a repeated start so a dummy write steers the read
            s_next.st     = spl_pkg::DS_RX;
            s_next.bitc   = 4'h0;
            s_next.nbyte  = 2'h0;
            s_next.sda_oe = 1'b0;
        end else if (stop_cond) begin
            s_next.st     = spl_pkg::DS_IDLE;
            s_next.sda_oe = 1'b0;
        end else begin
            case (s_reg.st)
                spl_pkg::DS_RX: begin
                    if (scl_rise) begin
                        s_next.sh   = {s_reg.sh[6:0], s_reg.sda_sy[1]};
                        s_next.bitc = s_reg.bitc + 4'h1;
                    end else if (scl_fall && s_reg.bitc == `SPL_BITS_BYTE)
                    begin
                        s_next.bitc = 4'h0;
                        case (s_reg.nbyte)
                            2'h0: begin
                                hit_sec = s_reg.sh[7:4] == `SPL_HDR_SEC &&
                                          s_reg.sh[3:1] == s_reg.sel;
                                hit_arr = s_reg.sh[7:4] == `SPL_HDR_ARR &&
                                          s_reg.sh[3:1] == s_reg.sel;
                                ack = hit_sec | hit_arr;
                                if (ack) begin
                                    s_next.arr = hit_arr;
                                    s_next.rw  = s_reg.sh[0];
                                end
                            end
                            2'h1: begin
                                s_next.kind = s_reg.sh[2:1];
                                ack = 1'b1;
                            end
                            2'h2: begin
                                ack = 1'b1;
                            end
                            default: begin
                                ack = 1'b1;
                                // protected writes are refused at the data
                                if (!s_reg.arr &&
                                    s_reg.kind == `SPL_KIND_SEC &&
                                    s_reg.lock) begin
                                    ack = 1'b0;
                                end
                                if (s_reg.swp &&
                                    s_reg.kind != `SPL_KIND_CFG) begin
                                    ack = 1'b0;
                                end
                                if (!s_reg.arr &&
                                    s_reg.kind == `SPL_KIND_LOCK &&
                                    s_reg.sh == `SPL_ERASED &&
                                    !s_reg.swp) begin
                                    s_next.lock = 1'b1;
                                end
                                if (!s_reg.arr &&
                                    s_reg.kind == `SPL_KIND_CFG) begin
                                    if (!s_reg.swp) begin
                                        s_next.sel = s_reg.sh[
                                            `SPL_CFG_SEL_HI:`SPL_CFG_SEL_LO];
                                        s_next.swp =
                                            s_reg.sh[`SPL_CFG_SWP_POS];
                                    end else if
                                        (!s_reg.sh[`SPL_CFG_SWP_POS]) begin
                                        // only clearing swp is allowed
                                        s_next.swp = 1'b0;
                                    end
                                end
                            end
                        endcase
                        if (s_reg.nbyte != `SPL_DATA_BYTE) begin
                            s_next.nbyte = s_reg.nbyte + 2'h1;
                        end
                        if (ack) begin
                            s_next.sda_oe = 1'b1;
                            s_next.st     = spl_pkg::DS_ACK;
                        end else begin
                            // silent until the next start or stop
                            s_next.st = spl_pkg::DS_IDLE;
                        end
                    end
                end
                spl_pkg::DS_ACK: begin
                    if (scl_fall) begin
                        s_next.sda_oe = 1'b0;
                        s_next.st     = spl_pkg::DS_RX;
                        if (s_reg.rw) begin
                            tx = tx_byte(s_reg.arr, s_reg.kind, s_reg.lock,
                                         s_reg.sel, s_reg.swp);
                            s_next.sda_oe = ~tx[7];
                            s_next.sh     = {tx[6:0], 1'b0};
                            s_next.bitc   = 4'h1;
                            s_next.st     = spl_pkg::DS_TX;
                        end
                    end
                end
                spl_pkg::DS_TX: begin
                    if (scl_fall) begin
                        if (s_reg.bitc == `SPL_BITS_BYTE) begin
                            s_next.sda_oe = 1'b0;
                            s_next.bitc   = 4'h0;
                            s_next.st     = spl_pkg::DS_MACK;
                        end else begin
                            s_next.sda_oe = ~s_reg.sh[7];
                            s_next.sh     = {s_reg.sh[6:0], 1'b0};
                            s_next.bitc   = s_reg.bitc + 4'h1;
                        end
                    end
                end
                spl_pkg::DS_MACK: begin
                    if (scl_rise && s_reg.sda_sy[1]) begin
                        s_next.st = spl_pkg::DS_IDLE;
                    end else if (scl_fall) begin
                        // acknowledged: repeat the same selection
                        tx = tx_byte(s_reg.arr, s_reg.kind, s_reg.lock,
                                     s_reg.sel, s_reg.swp);
                        s_next.sda_oe = ~tx[7];
                        s_next.sh     = {tx[6:0], 1'b0};
                        s_next.bitc   = 4'h1;
                        s_next.st     = spl_pkg::DS_TX;
                    end
                end
                default: begin
                    s_next.st = spl_pkg::DS_IDLE;
                end
            endcase
        end
    end

    // reset stands for the shipped state; no stored image survives it
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_reg        <= '0;
            s_reg.st     <= spl_pkg::DS_IDLE;
            s_reg.scl_sy <= 3'h7;
            s_reg.sda_sy <= 3'h7;
            s_reg.lock   <= `SPL_LOCK_RST;
            s_reg.sel    <= `SPL_SEL_RST;
            s_reg.swp    <= `SPL_SWP_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    assign bus.sda_d_o     = 1'b0;
    assign bus.sda_d_oe    = s_reg.sda_oe;
    assign locked          = s_reg.lock;
    assign dev_select_bit2 = s_reg.sel[2];
    assign dev_select_bit1 = s_reg.sel[1];
    assign dev_select_bit0 = s_reg.sel[0];
    assign write_protect   = s_reg.swp;

endmodule : spl_dev

/* core/spl_host.sv */
// master end: probes or reads the secure page lock state
// assumes a 20 MHz clk; makes scl itself by a quarter-bit divider
`timescale 1ns/100ps
`include "spl_map.svh"
module spl_host (
    // system
    input  wire logic            clk,
    input  wire logic            arst_n,
    // link
    spl_if.host                  bus,
    // command
    input  wire logic            go,
    input  wire spl_pkg::spl_op_t op,
    input  wire logic [2:0]      sel,
    // answer
    output wire logic            busy,
    output wire logic            done,
    output wire logic            acked,
    output wire logic [7:0]      status,
    output wire logic            locked
);

    localparam logic [5:0] QTR_LAST = 6'(`SPL_QTR_CYC - 1);

    // step table for both operations
    function automatic spl_pkg::spl_act_t step_act(
        input spl_pkg::spl_op_t o,
        input logic [3:0]       st,
        input logic [2:0]       sl
    );
        spl_pkg::spl_act_t a;
        a.st   = spl_pkg::HS_WRB;
        a.data = `SPL_ZERO;
        if (o == spl_pkg::OP_PROBE) begin
            case (st)
                4'h0: a.st = spl_pkg::HS_START;
                4'h1: a.data = {`SPL_HDR_SEC, sl, 1'b0};
                4'h4: a.data = `SPL_ERASED;
                4'h5: a.st = spl_pkg::HS_START;
                4'h6: a.st = spl_pkg::HS_STOP;
                4'h2, 4'h3: a.data = `SPL_ZERO;
                default: a.st = spl_pkg::HS_IDLE;
            endcase
        end else begin
            case (st)
                4'h0: a.st = spl_pkg::HS_START;
                4'h1: a.data = {`SPL_HDR_SEC, sl, 1'b0};
                4'h2: a.data = `SPL_ADDR_LOCK;
                4'h3: a.data = `SPL_ZERO;
                4'h4: a.st = spl_pkg::HS_START;
                4'h5: a.data = {`SPL_HDR_SEC, sl, 1'b1};
                4'h6: a.st = spl_pkg::HS_RDB;
                4'h7: a.st = spl_pkg::HS_STOP;
                default: a.st = spl_pkg::HS_IDLE;
            endcase
        end
        return a;
    endfunction : step_act

    spl_pkg::spl_host_s_t s_reg;
    spl_pkg::spl_host_s_t s_next;

    always_comb begin
        spl_pkg::spl_act_t a;
        logic [3:0]        nstep;
        logic              fin;
        a      = '0;
        nstep  = 4'h0;
        fin    = 1'b0;
        s_next = s_reg;
        s_next.done   = 1'b0;
        s_next.sda_sy = {s_reg.sda_sy[0], bus.sda};
        if (s_reg.st == spl_pkg::HS_IDLE) begin
            if (go) begin
                s_next.op    = op;
                s_next.sel   = sel;
                s_next.busy  = 1'b1;
                s_next.acked = 1'b1;
                s_next.nack  = 1'b0;
                s_next.step  = 4'h0;
                s_next.q     = 2'h0;
                s_next.div   = 6'h0;
                s_next.st    = spl_pkg::HS_START;
            end
        end else if (s_reg.div != QTR_LAST) begin
            s_next.div = s_reg.div + 6'h1;
        end else begin
            s_next.div = 6'h0;
            s_next.q   = s_reg.q + 2'h1;
            case (s_reg.q)
                2'h0: begin
                    s_next.scl = 1'b0;
                    case (s_reg.st)
                        spl_pkg::HS_START: s_next.sda_oe = 1'b0;
                        spl_pkg::HS_STOP:  s_next.sda_oe = 1'b1;
                        spl_pkg::HS_WRB:   s_next.sda_oe =
                            s_reg.bitc != `SPL_BITS_BYTE && !s_reg.sh[7];
                        default:           s_next.sda_oe = 1'b0;
                    endcase
                end
                2'h1: s_next.scl = 1'b1;
                2'h2: begin
                    if (s_reg.st == spl_pkg::HS_START) begin
                        s_next.sda_oe = 1'b1;
                    end else if (s_reg.st == spl_pkg::HS_STOP) begin
                        s_next.sda_oe = 1'b0;
                    end else if (s_reg.st == spl_pkg::HS_WRB &&
                                 s_reg.bitc == `SPL_BITS_BYTE) begin
                        s_next.nack = s_reg.sda_sy[1];
                    end else if (s_reg.st == spl_pkg::HS_RDB &&
                                 s_reg.bitc != `SPL_BITS_BYTE) begin
                        s_next.sh = {s_reg.sh[6:0], s_reg.sda_sy[1]};
                    end
                end
                default: begin
                    if (s_reg.st != spl_pkg::HS_STOP) begin
                        s_next.scl = 1'b0;
                    end
                    fin = s_reg.st == spl_pkg::HS_START ||
                          s_reg.st == spl_pkg::HS_STOP ||
                          s_reg.bitc == `SPL_BITS_BYTE;
                    s_next.bitc = s_reg.bitc + 4'h1;
                    if (s_reg.st == spl_pkg::HS_WRB) begin
                        s_next.sh = {s_reg.sh[6:0], 1'b0};
                    end
                end
            endcase
            if (fin) begin
                nstep = s_reg.step + 4'h1;
                if (s_reg.st == spl_pkg::HS_RDB) begin
                    s_next.status = s_reg.sh;
                    s_next.locked = s_reg.sh[`SPL_LOCK_POS];
                end
                if (s_reg.st == spl_pkg::HS_WRB && s_reg.nack) begin
                    s_next.acked = 1'b0;
                    nstep = (s_reg.op == spl_pkg::OP_PROBE) ?
                            `SPL_PROBE_TAIL : `SPL_STAT_TAIL;
                end
                a = step_act(s_reg.op, nstep, s_reg.sel);
                s_next.step = nstep;
                s_next.st   = a.st;
                s_next.sh   = a.data;
                s_next.bitc = 4'h0;
                if (a.st == spl_pkg::HS_IDLE) begin
                    s_next.busy = 1'b0;
                    s_next.done = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_reg        <= '0;
            s_reg.st     <= spl_pkg::HS_IDLE;
            s_reg.op     <= spl_pkg::OP_PROBE;
            s_reg.scl    <= 1'b1;
            s_reg.sda_sy <= 2'h3;
        end else begin
            s_reg <= s_next;
        end
    end

    assign bus.scl      = s_reg.scl;
    assign bus.sda_h_o  = 1'b0;
    assign bus.sda_h_oe = s_reg.sda_oe;
    assign busy         = s_reg.busy;
    assign done         = s_reg.done;
    assign acked        = s_reg.acked;
    assign status       = s_reg.status;
    assign locked       = s_reg.locked;

endmodule : spl_host

/* tb/spl_link_asserts.sv */
// checker on the master-to-eeprom link
// assumes every link signal is a flop output in the clk domain
`timescale 1ns/100ps
module spl_link_asserts (
    // system
    input wire logic clk,
    input wire logic arst_n,
    // link
    input wire logic scl,
    input wire logic sda,
    input wire logic sda_h_oe,
    input wire logic sda_d_oe
);
    logic       scl_d;
    logic       sda_q;
    logic       rdf;
    logic [3:0] cnt;
    logic [1:0] nb;
    logic [7:0] sh;
    logic [6:0] whdr;

    // nb starts saturated: no judging before a start
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            scl_d <= 1'b1;
            sda_q <= 1'b1;
            rdf   <= 1'b0;
            cnt   <= 4'h0;
            nb    <= 2'h3;
            sh    <= 8'h00;
            whdr  <= 7'h00;
        end else begin
            scl_d <= scl;
            sda_q <= sda;
            if (scl && scl_d && sda_q && !sda) begin
                cnt <= 4'h0;
                nb  <= 2'h0;
            end else if (scl && !scl_d) begin
                cnt <= (cnt == 4'h9) ? 4'h1 : cnt + 4'h1;
                nb  <= (cnt == 4'h9 && nb != 2'h3) ? nb + 2'h1 : nb;
                sh  <= {sh[6:0], sda};
                if (cnt == 4'h7 && nb == 2'h0) begin
                    rdf <= sda;
                end
            end
            if (scl_d && cnt == 4'h8 && nb == 2'h0 && !rdf) begin
                whdr <= sh[7:1];
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    a_hdr_prefix: assert property ($rose(scl_d) && cnt == 4'h8
        && nb == 2'h0 |-> sh[7:4] == 4'hb) else $error("bad header");
    a_dummy_kind: assert property ($rose(scl_d) && cnt == 4'h8
        && nb == 2'h1 && !rdf |-> sh[2:1] == 2'h0 || sh[2:1] == 2'h2)
        else $error("bad address kind");
    a_read_hdr: assert property ($rose(scl_d) && cnt == 4'h8
        && nb == 2'h0 && sh[0] |-> sh[7:1] == whdr)
        else $error("read header differs");
    a_status_bits: assert property ($rose(scl_d) && cnt == 4'h8
        && nb == 2'h1 && rdf |-> sh[7:2] == 6'h00 && !sh[0])
        else $error("status byte spare bits set");
    a_dev_low_only: assert property ($changed(sda_d_oe)
        |-> !scl && !$past(scl)) else $error("device moved sda at scl high");
    a_cond_master: assert property (scl && $past(scl) && $changed(sda)
        |-> $changed(sda_h_oe)) else $error("condition not from master");
    a_stop_idle: assert property (scl && $past(scl) && $rose(sda)
        |-> !sda_d_oe [*8]) else $error("device drove after stop");
    a_start_quiet: assert property (scl && $past(scl) && $fell(sda)
        |-> !sda_d_oe [*8]) else $error("device drove after start");
endmodule : spl_link_asserts

/* tb/secure_page_lock_status_tb.sv */
// bench: master and eeprom ends on one link, a second eeprom end
// on a link that the bench bit-bangs at a 400 ns serial clock
// assumes spl_if, spl_host and spl_dev from pkg/ and core/
`timescale 1ns/100ps
module secure_page_lock_status_tb;
    logic             clk;
    logic             arst_n;
    logic             go;
    spl_pkg::spl_op_t op;
    logic [2:0]       sel;
    logic             busy;
    logic             done;
    logic             acked;
    logic [7:0]       status;
    logic             h_lock;
    logic             d_lock;
    logic [2:0]       d_sel;
    logic             d_wp;
    logic             e_lock;
    int               miscompares;
    int               checks;
    logic [7:0]       rd;
    logic             ak;

    spl_if lk1 ();
    spl_if lk2 ();
    spl_host spl_host_inst (.clk(clk), .arst_n(arst_n), .bus(lk1),
        .go(go), .op(op), .sel(sel), .busy(busy), .done(done),
        .acked(acked), .status(status), .locked(h_lock));
    spl_dev spl_dev_inst (.clk(clk), .arst_n(arst_n), .bus(lk1),
        .locked(d_lock), .dev_select_bit2(d_sel[2]),
        .dev_select_bit1(d_sel[1]), .dev_select_bit0(d_sel[0]),
        .write_protect(d_wp));
    spl_dev spl_dev_inst_2 (.clk(clk), .arst_n(arst_n), .bus(lk2),
        .locked(e_lock), .dev_select_bit2(), .dev_select_bit1(),
        .dev_select_bit0(), .write_protect());
    spl_link_asserts spl_link_asserts_inst (.clk(clk), .arst_n(arst_n),
        .scl(lk1.scl), .sda(lk1.sda), .sda_h_oe(lk1.sda_h_oe),
        .sda_d_oe(lk1.sda_d_oe));

    always #25 clk = ~clk;

    task automatic end_of_test;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : end_of_test

    task automatic chk(input string nm, input logic [7:0] e, g);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // done is waited for under a bound; a hang miscompares
    task automatic host_op(input spl_pkg::spl_op_t o, input logic [2:0] s);
        int n;
        @(negedge clk);
        op = o;
        sel = s;
        go = 1'b1;
        @(negedge clk);
        go = 1'b0;
        chk("busy", 8'h01, {7'h0, busy});
        n = 0;
        while (done !== 1'b1 && n < 20000) begin
            @(negedge clk);
            n++;
        end
        chk("done", 8'h01, {7'h0, done});
    endtask : host_op

    task automatic qw;
        repeat (2) @(negedge clk);
    endtask : qw

    // sample late: the device answers a few clocks late
    task automatic bit_io(input logic b, output logic r);
        qw();
        lk2.sda_h_oe = ~b;
        qw();
        lk2.scl = 1'b1;
        qw();
        qw();
        r = lk2.sda;
        lk2.scl = 1'b0;
    endtask : bit_io

    task automatic b_start;
        qw();
        lk2.sda_h_oe = 1'b0;
        qw();
        lk2.scl = 1'b1;
        qw();
        lk2.sda_h_oe = 1'b1;
        qw();
        lk2.scl = 1'b0;
    endtask : b_start

    task automatic b_stop;
        qw();
        lk2.sda_h_oe = 1'b1;
        qw();
        lk2.scl = 1'b1;
        qw();
        lk2.sda_h_oe = 1'b0;
        qw();
    endtask : b_stop

    task automatic wbyte(input logic [7:0] d, output logic a);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, r);
        a = ~r;
    endtask : wbyte

    task automatic bb_read(input logic [7:0] h, a1, output logic [7:0] d,
                           output logic ok);
        logic x0, x1, x2, x3, r;
        b_start();
        wbyte(h, x0);
        wbyte(a1, x1);
        wbyte(8'h00, x2);
        b_start();
        wbyte(h | 8'h01, x3);
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(1'b1, r);
        b_stop();
        ok = x0 & x1 & x2 & x3;
    endtask : bb_read

    // ok reports the ack of the data byte only
    task automatic bb_write(input logic [7:0] h, a1, dat, input logic pr,
                            output logic ok);
        logic x0, x1, x2;
        b_start();
        wbyte(h, x0);
        wbyte(a1, x1);
        wbyte(8'h00, x2);
        wbyte(dat, ok);
        if (pr) b_start();
        b_stop();
    endtask : bb_write

    initial begin
        repeat (60000) @(posedge clk);
        miscompares++;
        end_of_test();
    end

    initial begin
        clk = 1'b0;
        arst_n = 1'b0;
        go = 1'b0;
        op = spl_pkg::OP_PROBE;
        sel = 3'h0;
        lk2.scl = 1'b1;
        lk2.sda_h_o = 1'b0;
        lk2.sda_h_oe = 1'b0;
        miscompares = 0;
        checks = 0;
        repeat (3) @(negedge clk);
        arst_n = 1'b1;
        chk("cfg_sel", 8'h00, {5'h0, d_sel});
        chk("swp", 8'h00, {7'h0, d_wp});
        chk("dev_lock", 8'h00, {7'h0, d_lock});
        $display("test shipped_state done");
        host_op(spl_pkg::OP_PROBE, 3'h0);
        chk("probe_ack", 8'h01, {7'h0, acked});
        host_op(spl_pkg::OP_STATUS, 3'h0);
        chk("status", 8'h00, status);
        chk("host_lock", 8'h00, {7'h0, h_lock});
        host_op(spl_pkg::OP_STATUS, 3'h5);
        chk("bad_sel_ack", 8'h00, {7'h0, acked});
        host_op(spl_pkg::OP_PROBE, 3'h0);
        chk("probe_again", 8'h01, {7'h0, acked});
        $display("test host_link done");
        bb_read(8'hb0, 8'h04, rd, ak);
        chk("lock_rd", 8'h00, rd);
        chk("lock_rd_ack", 8'h01, {7'h0, ak});
        bb_read(8'hb0, 8'h06, rd, ak);
        chk("cfg_rd", 8'h1d, rd);
        bb_read(8'ha0, 8'h00, rd, ak);
        chk("array_rd", 8'hff, rd);
        b_start();
        wbyte(8'hb4, ak);
        b_stop();
        chk("sel_nack", 8'h00, {7'h0, ak});
        bb_write(8'hb0, 8'h00, 8'hff, 1'b1, ak);
        chk("open_ack", 8'h01, {7'h0, ak});
        bb_write(8'hb0, 8'h04, 8'hff, 1'b0, ak);
        chk("locked", 8'h01, {7'h0, e_lock});
        bb_read(8'hb0, 8'h04, rd, ak);
        chk("lock_rd2", 8'h02, rd);
        bb_write(8'hb0, 8'h00, 8'hff, 1'b1, ak);
        chk("shut_ack", 8'h00, {7'h0, ak});
        bb_read(8'hb0, 8'h00, rd, ak);
        chk("page_rd", 8'hff, rd);
        bb_write(8'hb0, 8'h06, 8'h40, 1'b0, ak);
        bb_read(8'hb4, 8'h06, rd, ak);
        chk("cfg2", 8'h5d, rd);
        $display("test bitbang_link done");
        end_of_test();
    end
endmodule : secure_page_lock_status_tb
